// File: hdl/acs_fifo.sv
/*
 * Flip-flop FIFO with valid and ready on both sides and a flush.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic flush,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // acs_fifo
`default_nettype wire

// File: hdl/acs_params.svh
/*
 * Constants of the sync and power-down control block of a delta-sigma converter.
 * Assumes a single converter clock; the power-down threshold below is in periods of it, settling counts are in conversions.
 */
// Functional notes
// - Low beyond threshold enters power-down, else sync.
// - Falling sync halts conversion, clears filter counters.
// - Rising sync restarts conversion from reset state.
// - Shared pulse aligns starts to same clock.
// - SPI data-ready goes high when sync falls.
// - SPI data-ready stays high until settled data.
// - Frame format forces data low until settled.
// - Power-down stops circuitry, ignores digital inputs.
// - Power-down exit runs offset calibration, inputs shorted.
// - Mode change discards stored offset value.
// - SPI data-ready high after wake until settled.
// - Frame data low after wake until settled.
// - Outputs static in power-down; host drives inputs.
// - Oversampling 64 fast/low-power, 128 high-resolution.
// - Modulator rate is clock divided by mode divisor.
// - Settled after 76 conversions, 78 high-resolution.
// - Filter is linear phase, constant group delay.
// - Conversion lasts 256 or 512 clock periods.
// - SPI data-ready falls on result, rises on bit-clock fall.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_PDWN_LOW_CYCLES 524288
`define ACS_LOW_CNT_W 20
`define ACS_OSR_FAST 64
`define ACS_OSR_HIRES 128
`define ACS_DIV_FAST 4
`define ACS_DIV_HIRES 4
`define ACS_DIV_LOWPWR 8
`define ACS_DIV_W 4
`define ACS_CONV_CNT_W 9
`define ACS_SETTLE_FAST 76
`define ACS_SETTLE_HIRES 78
`define ACS_SETTLE_W 7
`define ACS_DATA_W 24
`define ACS_BITS_W 5
`define ACS_FIFO_DEPTH 8
`endif

// File: hdl/acs_pkg.sv
/*
 * Types shared by the sync and power-down control block.
 * Assumes acs_params.svh is on the include path.
 */
`include "acs_params.svh"
package acs_pkg;
    typedef enum logic [1:0] {
        acs_mode_fast,
        acs_mode_hires,
        acs_mode_lowpwr,
        acs_mode_spare
    } acs_mode_type;
    typedef enum logic [2:0] {
        acs_st_halt,
        acs_st_pdwn,
        acs_st_cal,
        acs_st_settle,
        acs_st_run
    } acs_state_type;
    typedef struct packed {
        logic signed [`ACS_DATA_W-1:0] data;
    } acs_result_type;
endpackage

// File: hdl/acs_sync_powerdown_n_ctrl.sv
/*
 * Conversion sequencing of a delta-sigma converter under one active-low
 * sync and power-down pin: decimation, offset calibration, settling and
 * result indication in SPI-style and frame-sync formats.
 * Assumes ref_clk is the converter clock and the modulator bit stream is
 * produced on that same clock; pins from the host are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module acs_sync_powerdown_n_ctrl
    import acs_pkg::*;
#(
    parameter int PDWN_LOW_CYCLES = `ACS_PDWN_LOW_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Host pins.
    input wire logic sync_powerdown_n,
    input wire acs_pkg::acs_mode_type mode_sel,
    input wire logic format_frame,
    input wire logic bit_clk,
    input wire logic frame_strobe,
    // Modulator stream.
    input wire logic modulator_bit,
    // Serial result side.
    output logic result_ready_n,
    output logic serial_data_out,
    // Status and analog control.
    output logic analog_short,
    output logic power_down,
    output logic converting
);
    import acs_pkg::*;

    // Two-stage synchronisers; a third stage feeds edge detection.
    logic [2:0] sync_s;
    logic [2:0] bclk_s;
    logic [2:0] fs_s;
    logic [1:0] fmt_s;
    acs_mode_type mode_s1;
    acs_mode_type mode_s2;
    acs_mode_type mode_prev;

    acs_state_type state;
    acs_state_type next_state;
    logic [`ACS_LOW_CNT_W-1:0] low_cnt;
    logic [`ACS_DIV_W-1:0] div_cnt;
    logic [`ACS_CONV_CNT_W-1:0] conv_cnt;
    logic [`ACS_SETTLE_W-1:0] settle_cnt;
    logic signed [`ACS_DATA_W-1:0] acc;
    logic signed [`ACS_DATA_W-1:0] offset;
    acs_result_type pending;
    logic pending_valid;
    logic [`ACS_DATA_W-1:0] shifter;
    logic [`ACS_BITS_W-1:0] bits_left;

    // Decode of synchronised pins.
    wire sync_hi = sync_s[1];
    wire sync_fall = sync_s[2] && !sync_s[1];
    wire bclk_fall = bclk_s[2] && !bclk_s[1];
    wire fs_rise = fs_s[1] && !fs_s[2];
    wire frame_fmt = fmt_s[1];
    wire mode_change = (mode_s2 != mode_prev);

    // Per-mode figures.
    wire [`ACS_DIV_W-1:0] div_sel = (mode_s2 == acs_mode_lowpwr) ? `ACS_DIV_W'(`ACS_DIV_LOWPWR) :
        (mode_s2 == acs_mode_hires) ? `ACS_DIV_W'(`ACS_DIV_HIRES) : `ACS_DIV_W'(`ACS_DIV_FAST);
    wire [`ACS_CONV_CNT_W:0] osr_sel = (mode_s2 == acs_mode_hires) ?
        (`ACS_CONV_CNT_W+1)'(`ACS_OSR_HIRES) : (`ACS_CONV_CNT_W+1)'(`ACS_OSR_FAST);
    // Conversion length is oversampling times divisor: 256 or 512 clocks.
    wire [`ACS_CONV_CNT_W:0] conv_len = (`ACS_CONV_CNT_W+1)'(osr_sel * div_sel);
    wire [`ACS_SETTLE_W-1:0] settle_len = (mode_s2 == acs_mode_hires) ?
        `ACS_SETTLE_W'(`ACS_SETTLE_HIRES) : `ACS_SETTLE_W'(`ACS_SETTLE_FAST);

    wire active = (state == acs_st_cal) || (state == acs_st_settle) || (state == acs_st_run);
    wire mod_tick = active && (div_cnt == div_sel - 1'b1);
    wire conv_end = active && ({1'b0, conv_cnt} == conv_len - 1'b1);
    // A plain boxcar over one conversion has symmetric taps, so its group
    // delay does not depend on frequency; stop-band depth is traded away.
    wire signed [`ACS_DATA_W-1:0] next_acc = mod_tick ?
        (modulator_bit ? acc + 1'b1 : acc - 1'b1) : acc;
    wire signed [`ACS_DATA_W-1:0] corrected = next_acc - offset;
    wire low_done = (low_cnt == `ACS_LOW_CNT_W'(PDWN_LOW_CYCLES - 1));
    wire settle_done = conv_end && (settle_cnt == settle_len - 1'b1);

    // FIFO between the filter and the serial side.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`ACS_DATA_W-1:0] fifo_out_data;
    wire fifo_flush = (state == acs_st_halt) || (state == acs_st_pdwn);
    wire spi_load = !frame_fmt && (state == acs_st_run) && fifo_out_valid && (bits_left == '0);
    wire frame_load = frame_fmt && fs_rise;
    wire fifo_pop = (spi_load || frame_load) && fifo_out_valid;

    acs_fifo #(
        .WIDTH(`ACS_DATA_W),
        .DEPTH(`ACS_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .flush(fifo_flush),
        .in_valid(pending_valid),
        .in_ready(fifo_in_ready),
        .in_data(pending.data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Next state.
    always_comb begin
        next_state = state;
        case (state)
            acs_st_halt: begin
                if (sync_hi) begin
                    next_state = acs_st_settle;
                end else if (low_done) begin
                    next_state = acs_st_pdwn;
                end
            end
            acs_st_pdwn: begin
                if (sync_hi) begin
                    next_state = acs_st_cal;
                end
            end
            acs_st_cal: begin
                if (conv_end) begin
                    next_state = acs_st_settle;
                end
            end
            acs_st_settle: begin
                if (settle_done) begin
                    next_state = acs_st_run;
                end
            end
            acs_st_run: begin
                next_state = acs_st_run;
            end
            default: begin
                next_state = acs_st_halt;
            end
        endcase
        // A new mode makes the running filter output meaningless, so results
        // are withheld again until the filter has settled in the new mode.
        if (state == acs_st_run && mode_change) begin
            next_state = acs_st_settle;
        end
        if (active && sync_fall) begin
            next_state = acs_st_halt;
        end
    end

    // Synchronisers; in power-down only the sync pin is watched, the other
    // host inputs are frozen so a running bit clock cannot disturb anything.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync_s <= 3'h0;
            bclk_s <= 3'h0;
            fs_s <= 3'h0;
            fmt_s <= 2'h0;
            mode_s1 <= acs_mode_fast;
            mode_s2 <= acs_mode_fast;
        end else begin
            sync_s <= {sync_s[1:0], sync_powerdown_n};
            if (state != acs_st_pdwn) begin
                bclk_s <= {bclk_s[1:0], bit_clk};
                fs_s <= {fs_s[1:0], frame_strobe};
                fmt_s <= {fmt_s[0], format_frame};
                mode_s1 <= mode_sel;
                mode_s2 <= mode_s1;
            end
        end
    end

    // Sequencer and saturating low-time counter.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= acs_st_halt;
            low_cnt <= '0;
        end else begin
            state <= next_state;
            if (sync_hi || state == acs_st_pdwn) begin
                low_cnt <= '0;
            end else if (!low_done) begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // Filter counters restart together on release, so every device fed the
    // same pulse and clock begins its conversions on the same edge.
    always_ff @(posedge ref_clk) begin
        if (!rstn || !active || mode_change) begin
            div_cnt <= '0;
            conv_cnt <= '0;
            acc <= '0;
            settle_cnt <= '0;
        end else begin
            div_cnt <= mod_tick ? '0 : div_cnt + 1'b1;
            conv_cnt <= conv_end ? '0 : conv_cnt + 1'b1;
            acc <= conv_end ? '0 : next_acc;
            if (conv_end && state == acs_st_settle) begin
                settle_cnt <= settle_cnt + 1'b1;
            end
        end
    end

    // Offset store; a new mode makes the old offset meaningless.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            offset <= '0;
            mode_prev <= acs_mode_fast;
        end else begin
            mode_prev <= mode_s2;
            if (mode_change) begin
                offset <= '0;
            end else if (state == acs_st_cal && conv_end) begin
                offset <= next_acc;
            end
        end
    end

    // Result waiting for the FIFO; an unread one is overwritten.
    always_ff @(posedge ref_clk) begin
        if (!rstn || fifo_flush) begin
            pending <= '0;
            pending_valid <= 1'b0;
        end else if (conv_end && (state == acs_st_run || settle_done)) begin
            pending.data <= corrected;
            pending_valid <= 1'b1;
        end else if (fifo_in_ready) begin
            pending_valid <= 1'b0;
        end
    end

    // Serial side: data-ready and the output shifter.
    always_ff @(posedge ref_clk) begin
        if (!rstn || fifo_flush) begin
            shifter <= '0;
            bits_left <= '0;
            result_ready_n <= 1'b1;
        end else if (spi_load || frame_load) begin
            shifter <= fifo_pop ? fifo_out_data : '0;
            bits_left <= `ACS_BITS_W'(`ACS_DATA_W);
            result_ready_n <= frame_fmt;
        end else if (bclk_fall && bits_left != '0) begin
            shifter <= {shifter[`ACS_DATA_W-2:0], 1'b0};
            bits_left <= bits_left - 1'b1;
            result_ready_n <= 1'b1;
        end
    end

    // Pin values for the next edge; the status pins are taken from the next state so
    // that they move on the same edge as the sequencer, the data pin from the current state.
    wire next_serial_data_out = (state == acs_st_run) && shifter[`ACS_DATA_W-1];
    wire next_analog_short = (next_state == acs_st_cal);
    wire next_power_down = (next_state == acs_st_pdwn);
    wire next_converting = (next_state == acs_st_run) || (next_state == acs_st_settle);

    // Registered pin drive; all static while powered down.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            serial_data_out <= 1'b0;
            analog_short <= 1'b0;
            power_down <= 1'b0;
            converting <= 1'b0;
        end else begin
            serial_data_out <= next_serial_data_out;
            analog_short <= next_analog_short;
            power_down <= next_power_down;
            converting <= next_converting;
        end
    end
endmodule // acs_sync_powerdown_n_ctrl
`default_nettype wire

// File: test/acs_ctrl_sva.sv
/* Port assertions for the sync and power-down control block.
   Assumes it is bound to acs_sync_powerdown_n_ctrl and shares its clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_sva #(
    parameter int PDWN_LOW_CYCLES = 64
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Pins.
    input wire logic sync_powerdown_n,
    input wire logic bit_clk,
    input wire logic result_ready_n,
    input wire logic serial_data_out,
    input wire logic analog_short,
    input wire logic power_down,
    input wire logic converting
);
    logic [19:0] low_cnt;
    logic [16:0] run_cnt;
    logic [9:0] cal_cnt;
    // Counters saturate so a long hold never wraps back into range.
    always_ff @(posedge ref_clk) begin
        low_cnt <= (!rstn || sync_powerdown_n) ? 20'h0 : low_cnt + 20'(low_cnt != 20'hfffff);
        run_cnt <= (!rstn || !converting) ? 17'h0 : run_cnt + 17'(run_cnt != 17'h1ffff);
        cal_cnt <= (!rstn || !analog_short) ? 10'h0 : cal_cnt + 10'(cal_cnt != 10'h3ff);
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_sync_halts: assert property ($fell(sync_powerdown_n) |-> ##[1:4] !converting)
        else $error("conversion not halted by sync");
    a_sync_ready_high: assert property ($fell(sync_powerdown_n) |-> ##[1:5] result_ready_n)
        else $error("ready not raised by sync");
    a_restart_conv: assert property ($rose(sync_powerdown_n) && !power_down |-> ##[1:6] converting)
        else $error("conversion not restarted");
    a_pdwn_not_early: assert property ($rose(power_down) |-> low_cnt >= PDWN_LOW_CYCLES)
        else $error("power-down entered too early");
    a_pdwn_not_late: assert property (low_cnt == 20'(PDWN_LOW_CYCLES + 6) |-> power_down)
        else $error("power-down not entered");
    a_pdwn_static: assert property (power_down |-> result_ready_n && !serial_data_out)
        else $error("outputs moved in power-down");
    a_cal_on_wake: assert property ($fell(power_down) |-> ##[0:3] analog_short)
        else $error("no calibration on wake");
    a_cal_length: assert property ($fell(analog_short) && sync_powerdown_n |->
        $past(cal_cnt) inside {[10'd254:10'd257], [10'd510:10'd513]})
        else $error("calibration length wrong");
    a_ready_settle: assert property (!converting && !$past(converting) |-> result_ready_n)
        else $error("ready low while not running");
    a_dout_quiet: assert property (!converting && !$past(converting) |-> !serial_data_out)
        else $error("data out not held low");
    a_settle_time: assert property ($fell(result_ready_n) |-> run_cnt >= 17'd19200)
        else $error("data before settling");
    a_ready_release: assert property (!result_ready_n && $fell(bit_clk) |-> ##[1:5] result_ready_n)
        else $error("ready not released by bit clock");
    c_pdwn: cover property ($rose(power_down));
    c_cal_done: cover property ($fell(analog_short));
    c_word: cover property ($fell(result_ready_n));
endmodule // acs_ctrl_sva
bind acs_sync_powerdown_n_ctrl acs_ctrl_sva #(.PDWN_LOW_CYCLES(PDWN_LOW_CYCLES)) acs_ctrl_sva_inst (
    .ref_clk(ref_clk), .rstn(rstn), .sync_powerdown_n(sync_powerdown_n), .bit_clk(bit_clk),
    .result_ready_n(result_ready_n), .serial_data_out(serial_data_out),
    .analog_short(analog_short), .power_down(power_down), .converting(converting));
`default_nettype wire

// File: test/acs_host_model.sv
/* Host reader of the serial result in SPI-style and frame-sync formats.
   Assumes bit_clk is sampled by the block on ref_clk with a few clocks of lag. */
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    // Clock.
    input wire logic ref_clk,
    // Format chosen by the bench.
    input wire logic frame_mode,
    // Serial pins.
    input wire logic result_ready_n,
    input wire logic serial_data_out,
    output logic bit_clk,
    output logic frame_strobe,
    // Captured word.
    output logic [23:0] word,
    output logic word_seen
);
    // The bit clock idles low between words, so it never floats or runs free.
    initial begin
        bit_clk = 1'b0;
        frame_strobe = 1'b0;
        word = 24'h0;
        word_seen = 1'b0;
        forever begin
            @(posedge ref_clk);
            word_seen <= 1'b0;
            if (frame_mode === 1'b1) begin
                // Frames follow back to back with the bit clock running through
                // them; falls beyond the 24th are ignored by the block.
                frame_strobe <= 1'b1;
                repeat (2) @(posedge ref_clk);
                frame_strobe <= 1'b0;
                repeat (3) @(posedge ref_clk);
                for (int i = 35; i >= 0; i--) begin
                    if (i >= 12) begin
                        word[i - 12] = serial_data_out;
                    end
                    bit_clk <= 1'b1;
                    repeat (2) @(posedge ref_clk);
                    bit_clk <= 1'b0;
                    repeat (5) @(posedge ref_clk);
                end
                word_seen <= 1'b1;
            end else if (result_ready_n === 1'b0) begin
                repeat (2) @(posedge ref_clk);
                for (int i = 23; i >= 0; i--) begin
                    word[i] = serial_data_out;
                    bit_clk <= 1'b1;
                    repeat (2) @(posedge ref_clk);
                    bit_clk <= 1'b0;
                    repeat (5) @(posedge ref_clk);
                end
                word_seen <= 1'b1;
            end
        end
    end
endmodule // acs_host_model
`default_nettype wire

// File: test/tb_adc_sync_powerdown_control.sv
/* Self-checking bench for the sync and power-down control block.
   Assumes the host model reads words and the modulator stream is all ones. */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sync_powerdown_control;
    import acs_pkg::*;
    localparam int PDWN = 64;
    logic ref_clk, rstn, sync_powerdown_n, modulator_bit, bit_clk, word_seen;
    logic result_ready_n, serial_data_out, analog_short, power_down, converting;
    logic format_frame, frame_strobe;
    acs_mode_type mode_sel;
    logic [23:0] word;
    int errors, checks_done;
    acs_sync_powerdown_n_ctrl #(.PDWN_LOW_CYCLES(PDWN)) acs_sync_powerdown_n_ctrl_inst (
        .ref_clk(ref_clk), .rstn(rstn), .sync_powerdown_n(sync_powerdown_n),
        .mode_sel(mode_sel), .format_frame(format_frame), .bit_clk(bit_clk),
        .frame_strobe(frame_strobe),
        .modulator_bit(modulator_bit), .result_ready_n(result_ready_n),
        .serial_data_out(serial_data_out), .analog_short(analog_short),
        .power_down(power_down), .converting(converting));
    acs_host_model acs_host_model_inst (.ref_clk(ref_clk), .frame_mode(format_frame),
        .result_ready_n(result_ready_n), .serial_data_out(serial_data_out), .bit_clk(bit_clk),
        .frame_strobe(frame_strobe), .word(word), .word_seen(word_seen));
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for a whole word; returns the cycles spent.
    task automatic wait_word(input int limit, output int n);
        n = 0;
        while (word_seen !== 1'b1) begin
            @(posedge ref_clk);
            n++;
            if (n > limit) begin
                errors++;
                $display("BAD word_wait expected word seen none");
                end_of_test();
            end
        end
    endtask
    task automatic sc_sync_pulse;
        sync_powerdown_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check_bit("converting", 1'b0, converting);
        check_bit("ready_n", 1'b1, result_ready_n);
        repeat (20) @(posedge ref_clk);
        check_bit("power_down", 1'b0, power_down);
        sync_powerdown_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check_bit("converting", 1'b1, converting);
    endtask
    task automatic sc_powerdown;
        int n;
        sync_powerdown_n <= 1'b0;
        repeat (PDWN + 8) @(posedge ref_clk);
        check_bit("power_down", 1'b1, power_down);
        check_bit("ready_n", 1'b1, result_ready_n);
        sync_powerdown_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check_bit("analog_short", 1'b1, analog_short);
        check_bit("converting", 1'b0, converting);
        repeat (256) @(posedge ref_clk);
        check_bit("analog_short", 1'b0, analog_short);
        wait_word(21000, n);
        check_bit("settle_long", 1'b1, n > 19400);
        check_word("word", 24'h000000, word);
    endtask
    task automatic sc_mode_change;
        int n;
        mode_sel <= acs_mode_hires;
        @(posedge ref_clk);
        wait_word(41000, n);
        check_bit("settle_long", 1'b1, n > 39800);
        check_word("word", 24'h000080, word);
    endtask
    // Frame format after a sync: every frame reads zero until the filter has
    // settled, so the first non-zero word marks the end of settling.
    task automatic sc_frame_format;
        int n;
        sync_powerdown_n <= 1'b0;
        mode_sel <= acs_mode_fast;
        format_frame <= 1'b1;
        repeat (20) @(posedge ref_clk);
        check_bit("dout_sync", 1'b0, serial_data_out);
        sync_powerdown_n <= 1'b1;
        n = 0;
        while (!(word_seen === 1'b1 && word !== 24'h000000)) begin
            @(posedge ref_clk);
            n++;
            if (n > 21000) begin
                errors++;
                $display("BAD frame_wait expected word seen none");
                end_of_test();
            end
        end
        check_bit("frame_settle", 1'b1, n > 19400);
        check_word("frame_word", 24'h000040, word);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        errors = 0;
        checks_done = 0;
        rstn = 1'b0;
        sync_powerdown_n = 1'b1;
        mode_sel = acs_mode_fast;
        format_frame = 1'b0;
        modulator_bit = 1'b1;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        sc_sync_pulse();
        sc_powerdown();
        sc_mode_change();
        sc_frame_format();
        end_of_test();
    end
endmodule // tb_adc_sync_powerdown_control
`default_nettype wire
